// ### mrwg_pkg.sv
// Shared constants and carrier types for the management RAM window guard
package mrwg_pkg;

  // ----------------------------------------------------------------
  // Address and field geometry
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W      = 52;
  localparam int unsigned FIELD_LO    = 17;
  localparam int unsigned FIELD_HI    = 51;
  localparam int unsigned FIELD_W     = FIELD_HI - FIELD_LO + 1;
  localparam int unsigned REG_W       = 64;
  localparam int unsigned CAP_W       = 32;

  // Fixed legacy window, inclusive bounds
  localparam logic [ADDR_W-1:0] LEGACY_LO = 52'h0_0000_000A_0000;
  localparam logic [ADDR_W-1:0] LEGACY_HI = 52'h0_0000_000B_FFFF;

  // Capability word location inside the saved-state area
  localparam logic [15:0] CAP_OFFSET      = 16'hFEFC;

  // Capability word field positions
  localparam int unsigned CAP_REV_LO      = 0;
  localparam int unsigned CAP_REV_HI      = 15;
  localparam int unsigned CAP_STEP_LO     = 8;
  localparam int unsigned CAP_IO_RESTART  = 16;
  localparam int unsigned CAP_RELOCATE    = 17;

  // Mask register enable bit positions
  localparam int unsigned MASK_LEGACY_ON  = 0;
  localparam int unsigned MASK_VAR_ON     = 1;

  // Window register select codes
  localparam logic SEL_BASE = 1'h0;
  localparam logic SEL_MASK = 1'h1;

  // Reset values of the window registers
  localparam logic [FIELD_W-1:0] FIELD_RESET = 35'h0_0000_0000;
  localparam logic               ENABLE_RESET = 1'h0;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic              valid;
    logic              write;
    logic [ADDR_W-1:0] addr;
  } mrwg_access_s;

  typedef struct packed {
    logic legacy_hit;
    logic variable_hit;
    logic guarded;
    logic cap_hit;
  } mrwg_result_s;

endpackage : mrwg_pkg

// ### mrwg_window_match.sv
// Combinational address classifier for the legacy and variable windows
`timescale 1ns/1ns
module mrwg_window_match (
  // Access address
  input  wire logic [mrwg_pkg::ADDR_W-1:0]  addr_in,
  // Window configuration
  input  wire logic [mrwg_pkg::FIELD_W-1:0] base_field_in,
  input  wire logic [mrwg_pkg::FIELD_W-1:0] mask_field_in,
  input  wire logic                         legacy_on_in,
  input  wire logic                         variable_on_in,
  // Classification
  output logic                              legacy_hit_out,
  output logic                              variable_hit_out
);

  // Masked compare of the upper address bits against the base field
  function automatic logic field_match(input logic [mrwg_pkg::FIELD_W-1:0] a,
                                       input logic [mrwg_pkg::FIELD_W-1:0] b,
                                       input logic [mrwg_pkg::FIELD_W-1:0] m);
    field_match = ((a & m) == (b & m));
  endfunction : field_match

  // ----------------------------------------------------------------
  // Window decode
  // ----------------------------------------------------------------
  always_comb begin
    legacy_hit_out   = legacy_on_in &&                                   // RULE_13
                       (addr_in >= mrwg_pkg::LEGACY_LO) &&
                       (addr_in <= mrwg_pkg::LEGACY_HI);                 // RULE_07
    variable_hit_out = variable_on_in &&                                 // RULE_14
                       field_match(addr_in[mrwg_pkg::FIELD_HI:mrwg_pkg::FIELD_LO],
                                   base_field_in, mask_field_in);        // RULE_10
  end

endmodule : mrwg_window_match

// ### mrwg_guard.sv
// Management RAM window guard: window registers, access classifier, capability word
`timescale 1ns/1ns
// Overview of operation
// (RULE_01) Capability word readable at saved-state offset FEFC
// (RULE_02) Software never writes the capability word
// (RULE_03) Low 16 bits hold revision level
// (RULE_04) Bit 16 fixed one: I/O restart
// (RULE_05) Bit 17 fixed one: base relocation
// (RULE_06) Bits above 17 reserved, read zero
// (RULE_07) Legacy window is A0000 through BFFFF
// (RULE_08) Base and mask registers define variable window
// (RULE_09) Software keeps the two windows apart
// (RULE_10) Masked address equals masked base means inside
// (RULE_11) Base field bits 51..17, others zero
// (RULE_12) Mask field bits 51..17 select compared bits
// (RULE_13) Mask bit 0 enables legacy window guard
// (RULE_14) Mask bit 1 enables variable window guard
// (RULE_15) Reserved bits read zero; enables clear at reset
module mrwg_guard #(
  // Revision step byte, starts at zero for the first revision
  parameter logic [7:0] REV_STEP = 8'h00,
  // Low revision byte; value is arbitrary
  parameter logic [7:0] REV_LOW  = 8'h5A
) (
  // Clock and reset
  input  wire logic                          clk_sys_in,
  input  wire logic                          reset_in,
  // Window register access from the core
  input  wire logic                          reg_wr_in,
  input  wire logic                          reg_rd_in,
  input  wire logic                          reg_sel_in,
  input  wire logic [mrwg_pkg::REG_W-1:0]    reg_wdata_in,
  output logic      [mrwg_pkg::REG_W-1:0]    reg_rdata_out,
  // Physical access from the core
  input  wire mrwg_pkg::mrwg_access_s        access_in,
  input  wire logic [31:0]                   state_origin_in,
  // Classification and capability word
  output mrwg_pkg::mrwg_result_s             result_out,
  output logic                               result_valid_out,
  output logic      [mrwg_pkg::CAP_W-1:0]    cap_rdata_out,
  output logic                               cap_write_seen_out
);

  // ----------------------------------------------------------------
  // Capability word
  // ----------------------------------------------------------------
  // Built from constants only, so no write path can ever alter it
  localparam logic [mrwg_pkg::CAP_W-1:0] CAP_WORD = {
    14'h0000,                                      // RULE_06
    1'h1,                                          // RULE_05
    1'h1,                                          // RULE_04
    REV_STEP,                                      // RULE_03
    REV_LOW
  };

  // ----------------------------------------------------------------
  // Window register state
  // ----------------------------------------------------------------
  logic [mrwg_pkg::FIELD_W-1:0] base_field;
  logic [mrwg_pkg::FIELD_W-1:0] mask_field;
  logic                         legacy_on;
  logic                         variable_on;
  logic [mrwg_pkg::FIELD_W-1:0] next_base_field;
  logic [mrwg_pkg::FIELD_W-1:0] next_mask_field;
  logic                         next_legacy_on;
  logic                         next_variable_on;
  logic [mrwg_pkg::REG_W-1:0]   next_reg_rdata;

  // Only the defined fields are stored; reserved bits have no flops at all
  always_comb begin
    next_base_field  = base_field;
    next_mask_field  = mask_field;
    next_legacy_on   = legacy_on;
    next_variable_on = variable_on;
    if (reg_wr_in) begin
      if (reg_sel_in == mrwg_pkg::SEL_BASE) begin
        next_base_field = reg_wdata_in[mrwg_pkg::FIELD_HI:mrwg_pkg::FIELD_LO]; // RULE_11
      end else begin
        next_mask_field  = reg_wdata_in[mrwg_pkg::FIELD_HI:mrwg_pkg::FIELD_LO]; // RULE_12
        next_legacy_on   = reg_wdata_in[mrwg_pkg::MASK_LEGACY_ON];         // RULE_13
        next_variable_on = reg_wdata_in[mrwg_pkg::MASK_VAR_ON];            // RULE_14
      end
    end
  end

  // Read-back assembles the fields; reserved bits are zero
  always_comb begin
    next_reg_rdata = reg_rdata_out;
    if (reg_rd_in) begin
      next_reg_rdata = '0;                                               // RULE_15
      if (reg_sel_in == mrwg_pkg::SEL_BASE) begin
        next_reg_rdata[mrwg_pkg::FIELD_HI:mrwg_pkg::FIELD_LO] = base_field;
      end else begin
        next_reg_rdata[mrwg_pkg::FIELD_HI:mrwg_pkg::FIELD_LO] = mask_field;
        next_reg_rdata[mrwg_pkg::MASK_LEGACY_ON] = legacy_on;
        next_reg_rdata[mrwg_pkg::MASK_VAR_ON]    = variable_on;
      end
    end
  end

  // Both guards come up disabled so boot code can place the windows first
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      base_field    <= mrwg_pkg::FIELD_RESET;
      mask_field    <= mrwg_pkg::FIELD_RESET;
      legacy_on     <= mrwg_pkg::ENABLE_RESET;                           // RULE_15
      variable_on   <= mrwg_pkg::ENABLE_RESET;                           // RULE_15
      reg_rdata_out <= '0;
    end else begin
      base_field    <= next_base_field;                                  // RULE_08
      mask_field    <= next_mask_field;                                  // RULE_08
      legacy_on     <= next_legacy_on;
      variable_on   <= next_variable_on;
      reg_rdata_out <= next_reg_rdata;
    end
  end

  // ----------------------------------------------------------------
  // Access classification
  // ----------------------------------------------------------------
  logic                          legacy_hit;
  logic                          variable_hit;
  logic [mrwg_pkg::ADDR_W-1:0]   cap_addr;
  logic                          cap_hit;
  mrwg_pkg::mrwg_result_s        next_result;
  logic                          next_result_valid;
  logic [mrwg_pkg::CAP_W-1:0]    next_cap_rdata;
  logic                          next_cap_write_seen;

  mrwg_window_match u_match (
    .addr_in          (access_in.addr),
    .base_field_in    (base_field),
    .mask_field_in    (mask_field),
    .legacy_on_in     (legacy_on),
    .variable_on_in   (variable_on),
    .legacy_hit_out   (legacy_hit),
    .variable_hit_out (variable_hit)
  );

  // Capability location follows the relocatable saved-state origin
  assign cap_addr = mrwg_pkg::ADDR_W'(state_origin_in) +
                    mrwg_pkg::ADDR_W'(mrwg_pkg::CAP_OFFSET);             // RULE_01
  assign cap_hit  = (access_in.addr == cap_addr);

  // Result is held between accesses; the valid strobe marks a fresh one
  always_comb begin
    next_result         = result_out;
    next_result_valid   = access_in.valid;
    next_cap_rdata      = cap_rdata_out;
    next_cap_write_seen = 1'h0;
    if (access_in.valid) begin
      next_result.legacy_hit   = legacy_hit;
      next_result.variable_hit = variable_hit;
      next_result.guarded      = legacy_hit | variable_hit;
      next_result.cap_hit      = cap_hit;
      if (cap_hit && !access_in.write) begin
        next_cap_rdata = CAP_WORD;                                       // RULE_01
      end
      // Writes here are undefined; flag them rather than store anything
      next_cap_write_seen = cap_hit && access_in.write;                  // RULE_02
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      result_out         <= '0;
      result_valid_out   <= 1'h0;
      cap_rdata_out      <= '0;
      cap_write_seen_out <= 1'h0;
    end else begin
      result_out         <= next_result;
      result_valid_out   <= next_result_valid;
      cap_rdata_out      <= next_cap_rdata;
      cap_write_seen_out <= next_cap_write_seen;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking chk_cb @(posedge clk_sys_in);
  endclocking
  default disable iff (reset_in);

  logic cap_read_now;
  assign cap_read_now = access_in.valid && cap_hit && !access_in.write;

  chk_cap_word_read: assert property ( // RULE_01
    cap_read_now |=> (cap_rdata_out == CAP_WORD) && result_out.cap_hit)
    else $error("capability word not returned after a read");

  chk_cap_rev_step: assert property ( // RULE_03
    cap_read_now |=> cap_rdata_out[15:8] == REV_STEP)
    else $error("revision step byte wrong");

  chk_cap_flag_bits: assert property ( // RULE_04
    cap_read_now |=> cap_rdata_out[mrwg_pkg::CAP_IO_RESTART] &&
                     cap_rdata_out[mrwg_pkg::CAP_RELOCATE])
    else $error("fixed capability bits not set");

  chk_cap_reserved_zero: assert property ( // RULE_06
    cap_read_now |=> cap_rdata_out[31:18] == 14'h0000)
    else $error("reserved capability bits not zero");

  chk_cap_write_flag: assert property ( // RULE_02
    (access_in.valid && cap_hit && access_in.write) |=>
      cap_write_seen_out ##1 !cap_write_seen_out || $past(access_in.valid))
    else $error("capability write not flagged");

  chk_legacy_window_hit: assert property ( // RULE_07
    (access_in.valid && legacy_on && access_in.addr >= mrwg_pkg::LEGACY_LO &&
     access_in.addr <= mrwg_pkg::LEGACY_HI) |=> result_out.legacy_hit && result_out.guarded)
    else $error("legacy window access not flagged");

  chk_legacy_guard_off: assert property ( // RULE_13
    (access_in.valid && !legacy_on) |=> !result_out.legacy_hit)
    else $error("legacy hit while its guard is off");

  chk_variable_match: assert property ( // RULE_10
    (access_in.valid && variable_on &&
     (((access_in.addr[mrwg_pkg::FIELD_HI:mrwg_pkg::FIELD_LO] ^ base_field) & mask_field) == '0))
      |=> result_out.variable_hit)
    else $error("variable window match missed");

  chk_variable_guard_off: assert property ( // RULE_14
    (access_in.valid && !variable_on) |=> !result_out.variable_hit)
    else $error("variable hit while its guard is off");

  chk_base_readback: assert property ( // RULE_11
    (reg_wr_in && reg_sel_in == mrwg_pkg::SEL_BASE) ##1 !reg_wr_in ##1
    (reg_rd_in && !reg_wr_in && reg_sel_in == mrwg_pkg::SEL_BASE) |=>
      reg_rdata_out == {12'h000, $past(reg_wdata_in[51:17], 3), 17'h00000})
    else $error("base register read-back wrong");

  chk_mask_reserved_zero: assert property ( // RULE_15
    (reg_rd_in && reg_sel_in == mrwg_pkg::SEL_MASK) |=>
      reg_rdata_out[63:52] == 12'h000 && reg_rdata_out[16:2] == 15'h0000)
    else $error("mask reserved bits not zero");

  chk_mask_enables: assert property ( // RULE_12
    (reg_wr_in && reg_sel_in == mrwg_pkg::SEL_MASK) |=>
      mask_field == $past(reg_wdata_in[51:17]) &&
      legacy_on == $past(reg_wdata_in[0]) && variable_on == $past(reg_wdata_in[1]))
    else $error("mask register write not applied");

  chk_reset_enables: assert property (@(posedge clk_sys_in) disable iff (1'b0) // RULE_15
    ($past(reset_in) && !reset_in) |-> !legacy_on && !variable_on)
    else $error("guards enabled after reset");

  cov_legacy_hit:   cover property (access_in.valid && legacy_hit);
  cov_variable_hit: cover property (access_in.valid && variable_hit);
  cov_cap_read:     cover property (cap_read_now ##1 result_valid_out);
  cov_cap_write:    cover property (cap_write_seen_out);

endmodule : mrwg_guard

// ### mrwg_core_model.sv
// Behavioural model of the core that issues physical accesses to the guard
`timescale 1ns/1ns
module mrwg_core_model (
  // Clock
  input  wire logic             clk_sys_in,
  // Physical access towards the guard
  output mrwg_pkg::mrwg_access_s access_out
);
  // ----------------------------------------------------------------
  // Access driver
  // ----------------------------------------------------------------
  // Idle at time zero so the guard never sees a stray access
  initial begin
    access_out = '0;
  end

  // One access per call; fields change on the falling edge only.
  // Software keeps the two windows apart, so stimulus never overlaps them.
  // A capability write is issued only when a scenario asks for it.
  task automatic issue(input logic wr, input logic [mrwg_pkg::ADDR_W-1:0] a);
    @(negedge clk_sys_in);
    access_out.valid = 1'b1;
    access_out.write = wr;
    access_out.addr  = a;
    @(negedge clk_sys_in);
    // Released lines show the inverse so a stale value never passes as valid
    access_out.valid = 1'b0;
    access_out.write = ~wr;
    access_out.addr  = ~a;
  endtask : issue
endmodule : mrwg_core_model

// ### mrwg_guard_tb_top.sv
// Self-checking testbench for the management RAM window guard
`timescale 1ns/1ns
module mrwg_guard_tb_top;
  // ----------------------------------------------------------------
  // Signals and expectations
  // ----------------------------------------------------------------
  logic                   clk_sys_in;
  logic                   reset_in;
  logic                   reg_wr_in;
  logic                   reg_rd_in;
  logic                   reg_sel_in;
  logic [63:0]            reg_wdata_in;
  logic [63:0]            reg_rdata_out;
  logic [31:0]            state_origin_in;
  mrwg_pkg::mrwg_access_s access_in;
  mrwg_pkg::mrwg_result_s result_out;
  logic                   result_valid_out;
  logic [31:0]            cap_rdata_out;
  logic                   cap_write_seen_out;
  int                     mismatches;
  int                     n_compared;
  localparam logic [7:0]  STEP    = 8'h02;
  localparam logic [7:0]  LOW     = 8'h5A; // Arbitrary value
  localparam logic [31:0] CAP_EXP = {14'h0000, 2'h3, STEP, LOW};

  // Design and core model
  mrwg_guard #(.REV_STEP(STEP), .REV_LOW(LOW)) uut (
    .clk_sys_in(clk_sys_in), .reset_in(reset_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_sel_in(reg_sel_in), .reg_wdata_in(reg_wdata_in),
    .reg_rdata_out(reg_rdata_out), .access_in(access_in),
    .state_origin_in(state_origin_in), .result_out(result_out),
    .result_valid_out(result_valid_out), .cap_rdata_out(cap_rdata_out),
    .cap_write_seen_out(cap_write_seen_out));
  mrwg_core_model core (.clk_sys_in(clk_sys_in), .access_out(access_in));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [63:0] exp, input logic [63:0] got, input string nm);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : close_out

  // Strobes last one cycle; the register answers on the clock edge that samples the read
  task automatic wr_reg(input logic sel, input logic [63:0] d);
    @(negedge clk_sys_in);
    reg_wr_in    = 1'b1;
    reg_sel_in   = sel;
    reg_wdata_in = d;
    @(negedge clk_sys_in);
    reg_wr_in    = 1'b0;
    reg_wdata_in = ~d;
  endtask : wr_reg

  task automatic rd_reg(input logic sel, input logic [63:0] exp, input string nm);
    @(negedge clk_sys_in);
    reg_rd_in  = 1'b1;
    reg_sel_in = sel;
    @(negedge clk_sys_in);
    reg_rd_in  = 1'b0;
    chk(exp, reg_rdata_out, nm);
  endtask : rd_reg

  // Result order is legacy, variable, guarded, capability
  task automatic acc(input logic wr, input logic [51:0] a, input logic [3:0] e,
                     input string nm);
    core.issue(wr, a);
    chk(64'h1, result_valid_out, "result_valid");
    chk(e, result_out, nm);
  endtask : acc

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    chk(64'h0, cap_rdata_out, "cap_reset");
    rd_reg(1'b0, 64'h0, "base_reset");
    rd_reg(1'b1, 64'h0, "mask_reset");
    acc(1'b0, 52'hA_0000, 4'h0, "legacy_off_reset");
  endtask : t_reset

  // All ones written: only the fields and the two enables stick
  task automatic t_reserved();
    wr_reg(1'b0, 64'hFFFF_FFFF_FFFF_FFFF);
    rd_reg(1'b0, 64'h000F_FFFF_FFFE_0000, "base_all_ones");
    wr_reg(1'b1, 64'hFFFF_FFFF_FFFF_FFFF);
    rd_reg(1'b1, 64'h000F_FFFF_FFFE_0003, "mask_all_ones");
  endtask : t_reserved

  // Boundaries of the fixed window, then with its enable cleared
  task automatic t_legacy();
    logic [51:0] a[4] = '{52'h9_FFFF, 52'hA_0000, 52'hB_FFFF, 52'hC_0000};
    logic [3:0]  e[4] = '{4'h0, 4'hA, 4'hA, 4'h0};
    wr_reg(1'b0, 64'h0);
    wr_reg(1'b1, 64'h1);
    for (int i = 0; i < 4; i++) begin
      acc(1'b0, a[i], e[i], "legacy_bound");
    end
    wr_reg(1'b1, 64'h0);
    acc(1'b0, 52'hA_0000, 4'h0, "legacy_disabled");
  endtask : t_legacy

  // A 256 KB variable window at 100000, an alias above it, then disabled
  task automatic t_variable();
    logic [51:0] a[5] = '{52'hF_FFFF, 52'h10_0000, 52'h13_FFFF, 52'h14_0000,
                          52'h1_0000_0010_0000};
    logic [3:0]  e[5] = '{4'h0, 4'h6, 4'h6, 4'h0, 4'h0};
    wr_reg(1'b0, 64'h0000_0000_0010_0000);
    wr_reg(1'b1, 64'h000F_FFFF_FFFC_0002);
    for (int i = 0; i < 5; i++) begin
      acc(1'b0, a[i], e[i], "variable_bound");
    end
    acc(1'b0, 52'hA_0000, 4'h0, "legacy_only_var_on");
    wr_reg(1'b1, 64'h000F_FFFF_FFFC_0000);
    acc(1'b0, 52'h10_0000, 4'h0, "variable_disabled");
  endtask : t_variable

  // Capability word read, a refused write to it, and a near miss
  task automatic t_cap();
    acc(1'b0, 52'h3_FEFC, 4'h1, "cap_read_hit");
    chk(CAP_EXP, cap_rdata_out, "cap_word");
    chk(64'h0, cap_write_seen_out, "cap_write_on_read");
    core.issue(1'b1, 52'h3_FEFC);
    chk(64'h1, cap_write_seen_out, "cap_write_flag");
    chk(CAP_EXP, cap_rdata_out, "cap_held_on_write");
    acc(1'b0, 52'h3_FEF8, 4'h0, "cap_near_miss");
    chk(64'h0, cap_write_seen_out, "cap_write_pulse");
    acc(1'b0, 52'h3_FEFC, 4'h1, "cap_reread");
    chk(CAP_EXP, cap_rdata_out, "cap_after_write");
    // Moving the saved-state origin must move the capability word with it
    state_origin_in = 32'h0004_0000;
    acc(1'b0, 52'h3_FEFC, 4'h0, "cap_old_origin");
    acc(1'b0, 52'h4_FEFC, 4'h1, "cap_relocated");
  endtask : t_cap

  // ----------------------------------------------------------------
  // Clock, reset, sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    clk_sys_in = 1'b0;
    forever #4 clk_sys_in = ~clk_sys_in;
  end

  initial begin
    mismatches      = 0;
    n_compared      = 0;
    reset_in        = 1'b1;
    reg_wr_in       = 1'b0;
    reg_rd_in       = 1'b0;
    reg_sel_in      = 1'b0;
    reg_wdata_in    = 64'h0;
    state_origin_in = 32'h0003_0000;
    repeat (20) @(negedge clk_sys_in);
    reset_in = 1'b0;
    t_reset();
    t_reserved();
    t_legacy();
    t_variable();
    t_cap();
    close_out();
  end

  // A hang counts as a mismatch and still reaches the verdict
  initial begin
    repeat (5000) @(posedge clk_sys_in);
    mismatches++;
    close_out();
  end
endmodule : mrwg_guard_tb_top
